// *** core/uarx_receiver.sv ***
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Ready flag high exactly while buffer nonempty.
// - Clearing enable flushes buffer, clears ready flag.
// - Irq follows ready flag while irq enabled.
// - Error status stored with each character.
// - Data read advances buffer read pointer.
// - Writes to error flags are ignored.
// - Error flags never raise interrupts.
// - Frame error from first stop bit only.
// - Overrun: full buffer, waiting char, new start.
// - Overrun cleared on successful buffer transfer.
// - Parity checked when high mode bit set.
// - Parity error kept if enabled at arrival.
// - Parity error reads zero when checking off.
// - Disable is immediate, frame abandoned.
// - Sixteen samples per bit, eight double speed.
// - Falling edge starts detection, sample one.
// - Start vote on samples 8-10 or 4-6.
// - Majority high rejects start as noise.
// - Resynchronise on every valid start bit.
// - Each bit decided by centre majority vote.
// - Store at first stop, ignore second.
// - Unused upper data bits read zero.
// - Enabled receiver takes over the pin.
module uarx_receiver (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sample_tick,
    input  wire logic        serial_rx_pin,
    output logic             rx_complete_irq,
    output logic             rx_pin_override
);
    logic                 rx_s1;
    logic                 rx_s2;
    logic                 rx_prev;
    logic                 double_speed_select;
    logic                 rx_complete_irq_enable;
    logic                 receiver_enable;
    logic [1:0]           parity_mode;
    logic                 stop_bit_select;
    logic [2:0]           char_size;
    uarx_pkg::uarx_state_t st;
    logic [4:0]           cnt;
    logic [1:0]           smp;
    logic [3:0]           bitn;
    logic [8:0]           shreg;
    logic                 parb;
    uarx_pkg::uarx_entry_t mem [2];
    uarx_pkg::uarx_entry_t pend;
    uarx_pkg::uarx_entry_t head;
    uarx_pkg::uarx_entry_t frame;
    logic                 pend_v;
    logic                 ovr;
    logic                 wp;
    logic                 rp;
    logic [1:0]           bcnt;
    logic [4:0]           spb;
    logic [4:0]           v1;
    logic [4:0]           v3;
    logic [3:0]           nbits;
    logic                 maj;
    logic                 at_vote;
    logic                 at_end;
    logic                 start_ok;
    logic                 start_rej;
    logic                 frame_done;
    logic                 wr;
    logic                 rd;
    logic                 hit;
    logic                 pop;
    logic                 room;
    logic                 push;
    logic                 rx_complete_flag;
    logic                 stat_upe;

    // The pin is asynchronous; only rx_s2 is looked at.
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= serial_rx_pin;
            rx_s2 <= rx_s1;
        end
    end

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign hit = paddr == uarx_pkg::OFS_STATUS || paddr == uarx_pkg::OFS_CTLB
              || paddr == uarx_pkg::OFS_CTLC || paddr == uarx_pkg::OFS_DATA;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // Only the speed bit of the status register is writable.
    always_ff @(posedge clock) begin
        if (reset) begin
            double_speed_select <= uarx_pkg::DS_RST;
            rx_complete_irq_enable <= 1'b0;
            receiver_enable <= 1'b0;
            parity_mode <= uarx_pkg::PM_RST;
            stop_bit_select <= 1'b0;
            char_size <= uarx_pkg::SZ_RST;
        end else if (wr) begin
            if (paddr == uarx_pkg::OFS_STATUS) begin
                double_speed_select <= pwdata[uarx_pkg::STAT_DS];
            end
            if (paddr == uarx_pkg::OFS_CTLB) begin
                rx_complete_irq_enable <= pwdata[uarx_pkg::CTLB_IRQEN];
                receiver_enable <= pwdata[uarx_pkg::CTLB_RXEN];
            end
            if (paddr == uarx_pkg::OFS_CTLC) begin
                parity_mode <= pwdata[uarx_pkg::CTLC_PM +: 2];
                stop_bit_select <= pwdata[uarx_pkg::CTLC_SBS];
                char_size <= pwdata[uarx_pkg::CTLC_SZ +: 3];
            end
        end
    end

    assign rx_pin_override = receiver_enable;
    // The sample tick already runs at 8x or 16x baud; we only count it.
    assign spb = double_speed_select ? uarx_pkg::SPB_DS : uarx_pkg::SPB_NORM;
    assign v1 = double_speed_select ? uarx_pkg::V1_DS : uarx_pkg::V1_NORM;
    assign v3 = v1 + 5'h02;
    assign nbits = (char_size == uarx_pkg::SZ_NINE) ? 4'h9
                 : char_size[2] ? 4'h8 : {2'h0, char_size[1:0]} + 4'h5;
    assign maj = (smp[1] & smp[0]) | (smp[1] & rx_s2) | (smp[0] & rx_s2);
    assign at_vote = sample_tick && cnt == v3;
    assign at_end = sample_tick && cnt == spb;
    assign start_ok = at_vote && st == uarx_pkg::ST_START && !maj;
    assign start_rej = at_vote && st == uarx_pkg::ST_START && maj;
    assign frame_done = at_vote && st == uarx_pkg::ST_STOP;

    always_comb begin
        frame.data = shreg;
        frame.fe = ~maj;
        frame.dor = ovr;
        // Odd mode inverts the expected parity.
        frame.upe = parity_mode[1] & (parb ^ (^shreg) ^ parity_mode[0]);
    end

    // Clearing the enable drops the frame at once.
    always_ff @(posedge clock) begin
        if (reset || !receiver_enable) begin
            st <= uarx_pkg::ST_IDLE;
            cnt <= 5'h01;
            smp <= 2'h3;
            bitn <= 4'h0;
            shreg <= 9'h000;
            parb <= 1'b0;
            rx_prev <= 1'b1;
        end else if (sample_tick) begin
            rx_prev <= rx_s2;
            cnt <= (at_end || st == uarx_pkg::ST_IDLE) ? 5'h01 : cnt + 5'h01;
            if (cnt == v1 || cnt == v1 + 5'h01) begin
                smp <= {smp[0], rx_s2};
            end
            case (st)
                uarx_pkg::ST_IDLE: begin
                    if (rx_prev && !rx_s2) begin
                        st <= uarx_pkg::ST_START;
                        cnt <= 5'h02;
                        shreg <= 9'h000;
                    end
                end
                uarx_pkg::ST_START: begin
                    if (start_rej) begin
                        st <= uarx_pkg::ST_IDLE;
                    end else if (at_end) begin
                        st <= uarx_pkg::ST_DATA;
                        bitn <= 4'h0;
                    end
                end
                uarx_pkg::ST_DATA: begin
                    if (at_vote) begin
                        shreg[bitn] <= maj;
                    end
                    if (at_end) begin
                        bitn <= bitn + 4'h1;
                        if (bitn == nbits - 4'h1) begin
                            st <= parity_mode[1] ? uarx_pkg::ST_PAR : uarx_pkg::ST_STOP;
                        end
                    end
                end
                uarx_pkg::ST_PAR: begin
                    if (at_vote) begin
                        parb <= maj;
                    end
                    if (at_end) begin
                        st <= uarx_pkg::ST_STOP;
                    end
                end
                uarx_pkg::ST_STOP: begin
                    // Back to idle right after the vote for an early next start.
                    if (at_vote) begin
                        st <= uarx_pkg::ST_IDLE;
                    end
                end
                default: st <= uarx_pkg::ST_IDLE;
            endcase
        end
    end

    assign pop = rd && paddr == uarx_pkg::OFS_DATA && bcnt != 2'h0;
    assign room = bcnt != 2'h2 || pop;
    assign push = room && (pend_v || frame_done);

    always_ff @(posedge clock) begin
        if (reset || !receiver_enable) begin
            pend_v <= 1'b0;
            pend <= '0;
            ovr <= 1'b0;
            wp <= 1'b0;
            rp <= 1'b0;
            bcnt <= 2'h0;
        end else begin
            if (push) begin
                // Status travels with the character into the buffer.
                mem[wp] <= pend_v ? pend : frame;
                wp <= ~wp;
                ovr <= 1'b0;
            end
            if (pend_v && room) begin
                pend_v <= frame_done;
                pend <= frame;
            end else if (frame_done && !room) begin
                pend_v <= 1'b1;
                pend <= frame;
            end
            if (start_ok && pend_v && !room) begin
                pend_v <= 1'b0;
                ovr <= 1'b1;
            end
            if (pop) begin
                rp <= ~rp;
            end
            bcnt <= bcnt + {1'b0, push} - {1'b0, pop};
        end
    end

    assign head = mem[rp];
    assign rx_complete_flag = bcnt != 2'h0;
    assign stat_upe = rx_complete_flag & head.upe & parity_mode[1];
    // Error flags feed no interrupt.
    assign rx_complete_irq = rx_complete_irq_enable & rx_complete_flag;

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                uarx_pkg::OFS_STATUS: begin
                    prdata[uarx_pkg::STAT_RXC] = rx_complete_flag;
                    prdata[uarx_pkg::STAT_FE] = rx_complete_flag & head.fe;
                    prdata[uarx_pkg::STAT_DOR] = rx_complete_flag & head.dor;
                    prdata[uarx_pkg::STAT_UPE] = stat_upe;
                    prdata[uarx_pkg::STAT_DS] = double_speed_select;
                end
                uarx_pkg::OFS_CTLB: begin
                    prdata[uarx_pkg::CTLB_IRQEN] = rx_complete_irq_enable;
                    prdata[uarx_pkg::CTLB_RXEN] = receiver_enable;
                    prdata[uarx_pkg::CTLB_RX8] = rx_complete_flag & head.data[8];
                end
                uarx_pkg::OFS_CTLC: begin
                    prdata[uarx_pkg::CTLC_PM +: 2] = parity_mode;
                    prdata[uarx_pkg::CTLC_SBS] = stop_bit_select;
                    prdata[uarx_pkg::CTLC_SZ +: 3] = char_size;
                end
                uarx_pkg::OFS_DATA: begin
                    prdata[7:0] = rx_complete_flag ? head.data[7:0] : 8'h00;
                end
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_rej;
        start_rej;
    endsequence

    property p_flush;
        !receiver_enable |=> bcnt == 2'h0 && !rx_complete_irq;
    endproperty
    a_flush: assert property (p_flush) else $error("buffer not flushed");

    property p_irq;
        rx_complete_irq |-> bcnt != 2'h0 && rx_complete_irq_enable;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without data");

    property p_pop;
        pop && !push |=> bcnt == $past(bcnt) - 2'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("read did not advance");

    property p_ovr;
        start_ok && pend_v && !room |=> ovr && !pend_v;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun missed");

    property p_ovr_clr;
        push && !(start_ok && pend_v) |=> !ovr;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");

    property p_upe;
        rd && paddr == uarx_pkg::OFS_STATUS && !parity_mode[1] |-> !prdata[uarx_pkg::STAT_UPE];
    endproperty
    a_upe: assert property (p_upe) else $error("parity error shown");

    property p_rej;
        s_rej |=> st == uarx_pkg::ST_IDLE;
    endproperty
    a_rej: assert property (p_rej) else $error("noise start kept");

    property p_dis;
        !receiver_enable |=> st == uarx_pkg::ST_IDLE;
    endproperty
    a_dis: assert property (p_dis) else $error("frame not abandoned");

    property p_full;
        bcnt == 2'h2 && !pop |=> bcnt == 2'h2 || !receiver_enable;
    endproperty
    a_full: assert property (p_full) else $error("data lost");
endmodule // uarx_receiver

`default_nettype wire

// *** core/uarx_pkg.sv ***
package uarx_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_CTLB   = 12'h004;
    localparam logic [11:0] OFS_CTLC   = 12'h008;
    localparam logic [11:0] OFS_DATA   = 12'h00c;
    // Status register fields.
    localparam int STAT_RXC = 7;
    localparam int STAT_FE  = 4;
    localparam int STAT_DOR = 3;
    localparam int STAT_UPE = 2;
    localparam int STAT_DS  = 1;
    // Control register b fields.
    localparam int CTLB_IRQEN = 7;
    localparam int CTLB_RXEN  = 4;
    localparam int CTLB_RX8   = 1;
    // Control register c fields: parity mode [5:4], stop select, size [2:0].
    localparam int CTLC_PM  = 4;
    localparam int CTLC_SBS = 3;
    localparam int CTLC_SZ  = 0;
    // Reset values and the nine-bit size code.
    localparam logic       DS_RST  = 1'b0;
    localparam logic [1:0] PM_RST  = 2'h0;
    localparam logic [2:0] SZ_RST  = 3'h3;
    localparam logic [2:0] SZ_NINE = 3'h7;
    // Samples per bit and first voting sample.
    localparam logic [4:0] SPB_NORM = 5'h10;
    localparam logic [4:0] SPB_DS   = 5'h08;
    localparam logic [4:0] V1_NORM  = 5'h08;
    localparam logic [4:0] V1_DS    = 5'h04;

    typedef struct packed {
        logic [8:0] data;
        logic       fe;
        logic       dor;
        logic       upe;
    } uarx_entry_t;

    typedef enum {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PAR,
        ST_STOP
    } uarx_state_t;
endpackage

// *** bench/uarx_tx_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// Remote transmitter: shifts bits out LSB first, spb ticks per bit.
// Between frames the line idles high.
module uarx_tx_model (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        sample_tick,
    input  wire logic        start,
    input  wire logic [15:0] bits,
    input  wire logic [3:0]  nbits,
    input  wire logic [4:0]  spb,
    output logic             line,
    output logic             busy
);
    logic [15:0] sh;
    logic [3:0]  left;
    logic [4:0]  tk;

    always_ff @(posedge clock) begin
        if (reset) begin
            line <= 1'b1;
            busy <= 1'b0;
            tk <= 5'h00;
        end else if (start && !busy) begin
            busy <= 1'b1;
            sh <= bits;
            left <= nbits;
            tk <= 5'h00;
        end else if (busy && sample_tick) begin
            if (tk == 5'h00) begin
                if (left == 4'h0) begin
                    busy <= 1'b0;
                    line <= 1'b1;
                end else begin
                    line <= sh[0];
                    sh <= sh >> 1;
                    left <= left - 4'h1;
                end
            end
            tk <= (tk == spb - 5'h01) ? 5'h00 : tk + 5'h01;
        end
    end
endmodule // uarx_tx_model

`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none

module testbench;
    localparam logic [11:0] AS = uarx_pkg::OFS_STATUS;
    localparam logic [11:0] AB = uarx_pkg::OFS_CTLB;
    localparam logic [11:0] AC = uarx_pkg::OFS_CTLC;
    localparam logic [11:0] AD = uarx_pkg::OFS_DATA;
    localparam logic [31:0] RXC = 32'h0000_0001 << uarx_pkg::STAT_RXC;
    localparam logic [31:0] FE  = 32'h0000_0001 << uarx_pkg::STAT_FE;
    localparam logic [31:0] DOR = 32'h0000_0001 << uarx_pkg::STAT_DOR;
    localparam logic [31:0] UPE = 32'h0000_0001 << uarx_pkg::STAT_UPE;
    localparam logic [31:0] DS  = 32'h0000_0001 << uarx_pkg::STAT_DS;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        sample_tick = 1'b0;
    logic [1:0]  tcnt = 2'h0;
    logic        start = 1'b0;
    logic [15:0] bits = 16'hffff;
    logic [3:0]  nbits = 4'h0;
    logic [4:0]  spb = 5'h10;
    wire logic [31:0] prdata;
    wire logic        pready;
    wire logic        pslverr;
    wire logic        irq;
    wire logic        ovr;
    wire logic        line;
    wire logic        busy;
    int          n_fail = 0;
    int          cmp_count = 0;

    uarx_receiver i_uarx_receiver (.clock(clock), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_tick(sample_tick), .serial_rx_pin(line),
        .rx_complete_irq(irq), .rx_pin_override(ovr));
    uarx_tx_model i_uarx_tx_model (.clock(clock), .reset(reset),
        .sample_tick(sample_tick), .start(start), .bits(bits), .nbits(nbits),
        .spb(spb), .line(line), .busy(busy));

    initial begin
        forever #25 clock = ~clock;
    end

    // Sample tick every fourth clock keeps a frame short.
    always @(posedge clock) begin
        tcnt <= tcnt + 2'h1;
        sample_tick <= (tcnt == 2'h3);
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, g, x);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Register updates of this edge settle before any caller looks at a pin.
        @(negedge clock);
        if (i == 50) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, x);
    endtask

    task automatic idle();
        int i;
        for (i = 0; i < 5000; i++) begin
            @(posedge clock);
            if (busy === 1'b0) break;
        end
        if (i == 5000) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    // Frame: start, n data bits, optional parity, first stop, one idle bit.
    task automatic send(input logic [8:0] d, input int n, input bit pen,
                        input logic pb, input logic sb, input bit wt);
        logic [15:0] v;
        int          k;
        v = 16'hffff;
        v[0] = 1'b0;
        for (k = 0; k < n; k++) v[k+1] = d[k];
        k = n + 1;
        if (pen) begin
            v[k] = pb;
            k++;
        end
        v[k] = sb;
        @(posedge clock);
        bits <= v;
        nbits <= 4'(k + 2);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        if (wt) idle();
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        rd(AS, 32'h0000_0000);
        rd(AB, 32'h0000_0000);
        rd(AC, 32'(uarx_pkg::SZ_RST));
        apb(1'b0, 12'h010, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        chk(32'(ovr), 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_basic();
        wr(AB, 32'h0000_0090);
        chk(32'(ovr), 32'h0000_0001);
        send(9'h0a5, 8, 0, 1'b0, 1'b1, 1);
        rd(AS, RXC);
        chk(32'(irq), 32'h0000_0001);
        rd(AD, 32'h0000_00a5);
        rd(AS, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        $display("test basic done");
    endtask

    task automatic t_overrun();
        wr(AB, 32'h0000_0010);
        send(9'h011, 8, 0, 1'b0, 1'b0, 1);
        send(9'h022, 8, 0, 1'b0, 1'b1, 1);
        send(9'h033, 8, 0, 1'b0, 1'b1, 1);
        send(9'h044, 8, 0, 1'b0, 1'b1, 1);
        chk(32'(irq), 32'h0000_0000);
        wr(AS, 32'h0000_0000);
        rd(AS, RXC | FE);
        rd(AD, 32'h0000_0011);
        rd(AS, RXC);
        rd(AD, 32'h0000_0022);
        rd(AS, RXC | DOR);
        rd(AD, 32'h0000_0044);
        rd(AS, 32'h0000_0000);
        send(9'h055, 8, 0, 1'b0, 1'b1, 1);
        rd(AS, RXC);
        rd(AD, 32'h0000_0055);
        $display("test overrun done");
    endtask

    task automatic t_parity();
        wr(AC, 32'h0000_0023);
        send(9'h007, 8, 1, 1'b0, 1'b1, 1);
        rd(AS, RXC | UPE);
        wr(AC, 32'h0000_0003);
        rd(AS, RXC);
        wr(AC, 32'h0000_0023);
        rd(AS, RXC | UPE);
        rd(AD, 32'h0000_0007);
        wr(AC, 32'h0000_0033);
        send(9'h007, 8, 1, 1'b0, 1'b1, 1);
        rd(AS, RXC);
        rd(AD, 32'h0000_0007);
        wr(AC, 32'(uarx_pkg::SZ_NINE));
        send(9'h1a5, 9, 0, 1'b0, 1'b1, 1);
        rd(AB, 32'h0000_0012);
        rd(AD, 32'h0000_00a5);
        wr(AC, 32'h0000_0000);
        send(9'h1ff, 5, 0, 1'b0, 1'b1, 1);
        rd(AD, 32'h0000_001f);
        $display("test parity done");
    endtask

    task automatic t_speed();
        wr(AC, 32'h0000_0003);
        spb <= 5'h04;
        send(9'h000, 0, 0, 1'b0, 1'b1, 1);
        rd(AS, 32'h0000_0000);
        wr(AS, DS);
        spb <= 5'h08;
        send(9'h05a, 8, 0, 1'b0, 1'b1, 1);
        rd(AS, RXC | DS);
        rd(AD, 32'h0000_005a);
        wr(AS, 32'h0000_0000);
        spb <= 5'h10;
        $display("test speed done");
    endtask

    task automatic t_disable();
        wr(AB, 32'h0000_0090);
        send(9'h066, 8, 0, 1'b0, 1'b1, 1);
        send(9'h077, 8, 0, 1'b0, 1'b1, 0);
        repeat (200) @(posedge clock);
        wr(AB, 32'h0000_0000);
        chk(32'(ovr), 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        rd(AS, 32'h0000_0000);
        idle();
        wr(AB, 32'h0000_0010);
        rd(AS, 32'h0000_0000);
        $display("test disable done");
    endtask

    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_basic();
        t_overrun();
        t_parity();
        t_speed();
        t_disable();
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
